// ==== rtl/iasf_pkg.sv ====
// What this block does
// - Mode field 01b selects I2S framing
// - I2S frame length field sets half frame
// - I2S master raises sync, sends first buffer
// - Default I2S word starts one bit late
// - Justified I2S: MSB on sync edge bit
// - After word, unused mode bit rules output
// - Link frame: 256 bits, tag plus slots
// - Link sync high 16, low 240 bits
// - Link data starts one bit after sync
// - Link: codec clock in, sync from it
// - Mode 10b 16-bit link, 11b 20-bit
// - 16-bit link truncates received slots
// - 16-bit link pads four low bits zero
// - 16-bit link keeps real slot boundaries
// - 20-bit link: sixteen 16-bit slots
// - Link modes ignore word and frame fields
// - 16-bit link uses slot enables 12..0
// - Length 01b flags every two words
// - Clock direction set: clock is input
// - Sync direction clear: master drives sync
// - Edge select set: sample rising edge
// - Slot enables gate transmit and receive
// - I2S master sync has 50% duty
// - Slave finishes frame, ignores extra syncs
package iasf_pkg;
  localparam logic [7:0] OFF_CTRL1 = 8'h00;
  localparam logic [7:0] OFF_CTRL2 = 8'h04;
  localparam logic [7:0] OFF_CLKGEN = 8'h08;
  localparam logic [7:0] OFF_STATUS = 8'h0C;
  localparam logic [7:0] OFF_TXEN = 8'h10;
  localparam logic [7:0] OFF_RXEN = 8'h14;
  localparam logic [3:0] TXBUF_HI = 4'h2;
  localparam logic [3:0] RXBUF_HI = 4'h3;
  localparam logic [15:0] CTRL1_WMASK = 16'h8763;
  localparam logic [11:0] CTRL2_WMASK = 12'hDEF;
  localparam int EN_BIT = 15;
  localparam int CLKDIR_BIT = 10;
  localparam int EDGE_BIT = 9;
  localparam int FSDIR_BIT = 8;
  localparam int UNUSED_BIT = 6;
  localparam int JUST_BIT = 5;
  localparam int MODE_LSB = 0;
  localparam int BUFFER_LENGTH_FIELD_LSB = 10;
  localparam int FLEN_LSB = 5;
  localparam int WS_LSB = 0;
  localparam int FLAG_BIT = 0;
  localparam logic [2:0] HSIZE_WORD = 3'h2;
  localparam logic [9:0] AC_FRAME = 10'h100;
  localparam logic [9:0] AC_FS_HIGH = 10'h010;
  localparam logic [4:0] AC_TAG_LEN = 5'h10;
  localparam logic [4:0] AC_SLOT_LEN = 5'h14;
  localparam logic [3:0] AC16_LAST = 4'hC;
  localparam logic [15:0] AC16_MASK = 16'h1FFF;
  localparam logic [3:0] FULL_FIELD = 4'hF;
  localparam logic [4:0] WORD_BITS = 5'h10;
  typedef enum logic [1:0] {
    MODE_MULTI = 2'b00,
    MODE_I2S = 2'b01,
    MODE_AC16 = 2'b10,
    MODE_AC20 = 2'b11
  } iasf_mode_t;
  typedef enum logic {
    LINK_IDLE = 1'b0,
    LINK_RUN = 1'b1
  } iasf_link_t;
endpackage

// ==== rtl/iasf_serial_framing.sv ====
`timescale 1ns/1ps
module iasf_serial_framing (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // Serial bit clock pin
  input wire logic serial_bit_clock_pin_in,
  output logic serial_bit_clock_pin_out,
  output logic serial_bit_clock_pin_oe_n,
  // Frame sync pin
  input wire logic frame_sync_pin_in,
  output logic frame_sync_pin_out,
  output logic frame_sync_pin_oe_n,
  // Serial data
  input wire logic serial_data_in_pin,
  output logic serial_data_out_pin_out,
  output logic serial_data_out_pin_oe_n,
  // Buffer event
  output logic interface_interrupt_flag
);

  typedef struct packed {
    logic [15:0] ctrl1;
    logic [11:0] ctrl2;
    logic [7:0] clkdiv;
    logic [15:0] txen;
    logic [15:0] rxen;
    logic [3:0][15:0] txbuf;
    logic [3:0][15:0] rxbuf;
    logic flag;
    logic wr_pend;
    logic [7:0] wr_addr;
    logic [31:0] hrdata;
    logic [1:0] sck_sync;
    logic [1:0] fs_sync;
    logic [1:0] sdi_sync;
    logic [7:0] div_cnt;
    logic sck_gen;
    logic bclk_d;
    iasf_pkg::iasf_link_t link;
    logic [9:0] bit_cnt;
    logic [3:0] slot;
    logic [4:0] sbit;
    logic [1:0] idx;
    logic data_on;
    logic tx_act;
    logic rx_act;
    logic [15:0] tx_sh;
    logic [15:0] rx_sh;
    logic fs_prev;
    logic fs_out;
    logic sdo;
  } iasf_state_t;

  iasf_state_t st;
  iasf_state_t n;

  logic en;
  logic clk_dir;
  logic edge_sel;
  logic fs_dir;
  logic unused_mode;
  logic just;
  iasf_pkg::iasf_mode_t mode;
  logic ac;
  logic i2s;
  logic [1:0] buffer_length_field;
  logic [3:0] fl_eff;
  logic [3:0] ws_eff;
  logic [4:0] word_len;
  logic [4:0] fl_p1;
  logic [9:0] half_len;
  logic [9:0] frame_len;
  logic [9:0] delay;
  logic [4:0] slot_len;
  logic [3:0] last_slot;
  logic [15:0] tx_mask;
  logic [15:0] rx_mask;
  logic bclk;
  logic drive_e;
  logic sample_e;
  logic fs_now;

  assign en = st.ctrl1[iasf_pkg::EN_BIT];
  assign clk_dir = st.ctrl1[iasf_pkg::CLKDIR_BIT];
  assign edge_sel = st.ctrl1[iasf_pkg::EDGE_BIT];
  assign fs_dir = st.ctrl1[iasf_pkg::FSDIR_BIT];
  assign unused_mode = st.ctrl1[iasf_pkg::UNUSED_BIT];
  assign just = st.ctrl1[iasf_pkg::JUST_BIT];
  assign mode = iasf_pkg::iasf_mode_t'(st.ctrl1[iasf_pkg::MODE_LSB +: 2]);
  assign ac = mode[1];
  assign i2s = (mode == iasf_pkg::MODE_I2S);
  assign buffer_length_field = st.ctrl2[iasf_pkg::BUFFER_LENGTH_FIELD_LSB +: 2];
  // Protocol fixes the sizes in both link modes
  assign fl_eff = ac ? iasf_pkg::FULL_FIELD : st.ctrl2[iasf_pkg::FLEN_LSB +: 4];
  assign ws_eff = ac ? iasf_pkg::FULL_FIELD : st.ctrl2[iasf_pkg::WS_LSB +: 4];
  assign word_len = {1'b0, ws_eff} + 5'h01;
  assign fl_p1 = {1'b0, fl_eff} + 5'h01;
  assign half_len = {5'h00, fl_p1} * {5'h00, word_len};
  // I2S field covers one half only
  assign frame_len = ac ? iasf_pkg::AC_FRAME :
                     i2s ? {half_len[8:0], 1'b0} : half_len;
  assign delay = (i2s && just) ? 10'h000 : 10'h001;
  // 16-bit link: tag slot is 16 bits, data slots 20
  assign slot_len = (mode != iasf_pkg::MODE_AC16) ? word_len :
                    (st.slot == 4'h0) ? iasf_pkg::AC_TAG_LEN : iasf_pkg::AC_SLOT_LEN;
  assign last_slot = (mode == iasf_pkg::MODE_AC16) ? iasf_pkg::AC16_LAST : fl_eff;
  assign tx_mask = (mode == iasf_pkg::MODE_AC16) ? (st.txen & iasf_pkg::AC16_MASK) : st.txen;
  assign rx_mask = (mode == iasf_pkg::MODE_AC16) ? (st.rxen & iasf_pkg::AC16_MASK) : st.rxen;
  assign bclk = clk_dir ? st.sck_sync[1] : st.sck_gen;
  // Launch on the edge opposite the sampling edge
  assign sample_e = edge_sel ? (bclk & ~st.bclk_d) : (~bclk & st.bclk_d);
  assign drive_e = edge_sel ? (~bclk & st.bclk_d) : (bclk & ~st.bclk_d);
  assign fs_now = st.fs_sync[1];

  logic take;
  logic flag_set;
  logic flag_clr;
  logic go;
  logic start;
  logic slot_end;
  logic ndon;
  logic [9:0] c;
  logic [3:0] nslot;
  logic [4:0] nsb;
  logic [1:0] ni;
  logic [15:0] word;
  logic [31:0] rd;

  always_comb begin
    n = st;
    take = 1'b0;
    flag_set = 1'b0;
    flag_clr = 1'b0;
    go = 1'b0;
    start = 1'b0;
    slot_end = 1'b0;
    ndon = 1'b0;
    c = 10'h000;
    nslot = st.slot;
    nsb = st.sbit;
    ni = st.idx;
    word = 16'h0000;
    rd = 32'h0000_0000;
    // Bus address phase
    take = hsel & hready & htrans[1] & (hsize == iasf_pkg::HSIZE_WORD);
    n.wr_pend = take & hwrite;
    n.wr_addr = haddr[7:0];
    case (haddr[7:0])
      iasf_pkg::OFF_CTRL1: rd = {16'h0000, st.ctrl1};
      iasf_pkg::OFF_CTRL2: rd = {20'h00000, st.ctrl2};
      iasf_pkg::OFF_CLKGEN: rd = {24'h000000, st.clkdiv};
      iasf_pkg::OFF_STATUS: begin
        rd = {20'h00000, st.slot, 5'h00, (fs_dir ? fs_now : st.fs_out),
              (st.link == iasf_pkg::LINK_RUN), st.flag};
      end
      iasf_pkg::OFF_TXEN: rd = {16'h0000, st.txen};
      iasf_pkg::OFF_RXEN: rd = {16'h0000, st.rxen};
      default: begin
        if (haddr[7:4] == iasf_pkg::TXBUF_HI) begin
          rd = {16'h0000, st.txbuf[haddr[3:2]]};
        end else if (haddr[7:4] == iasf_pkg::RXBUF_HI) begin
          rd = {16'h0000, st.rxbuf[haddr[3:2]]};
        end
      end
    endcase
    if (take && !hwrite) begin
      n.hrdata = rd;
    end
    // Bus data phase
    if (st.wr_pend) begin
      case (st.wr_addr)
        iasf_pkg::OFF_CTRL1: n.ctrl1 = hwdata[15:0] & iasf_pkg::CTRL1_WMASK;
        iasf_pkg::OFF_CTRL2: n.ctrl2 = hwdata[11:0] & iasf_pkg::CTRL2_WMASK;
        iasf_pkg::OFF_CLKGEN: n.clkdiv = hwdata[7:0];
        iasf_pkg::OFF_STATUS: flag_clr = hwdata[iasf_pkg::FLAG_BIT];
        iasf_pkg::OFF_TXEN: n.txen = hwdata[15:0];
        iasf_pkg::OFF_RXEN: n.rxen = hwdata[15:0];
        default: begin
          if (st.wr_addr[7:4] == iasf_pkg::TXBUF_HI) begin
            n.txbuf[st.wr_addr[3:2]] = hwdata[15:0];
          end
        end
      endcase
    end
    // Pin synchronisers
    n.sck_sync = {st.sck_sync[0], serial_bit_clock_pin_in};
    n.fs_sync = {st.fs_sync[0], frame_sync_pin_in};
    n.sdi_sync = {st.sdi_sync[0], serial_data_in_pin};
    n.bclk_d = bclk;
    // Bit clock generator, half period of clkdiv+1 cycles
    if (en && !clk_dir) begin
      if (st.div_cnt == st.clkdiv) begin
        n.div_cnt = 8'h00;
        n.sck_gen = ~st.sck_gen;
      end else begin
        n.div_cnt = st.div_cnt + 8'h01;
      end
    end else begin
      n.div_cnt = 8'h00;
      n.sck_gen = 1'b0;
    end
    if (!en) begin
      n.link = iasf_pkg::LINK_IDLE;
      n.bit_cnt = 10'h000;
      n.slot = 4'h0;
      n.sbit = 5'h00;
      n.idx = 2'h0;
      n.data_on = 1'b0;
      n.tx_act = 1'b0;
      n.rx_act = 1'b0;
      n.fs_out = 1'b0;
      n.sdo = 1'b0;
    end else if (drive_e) begin
      n.fs_prev = fs_now;
      // Close the current slot
      slot_end = st.data_on && (st.sbit == slot_len - 5'h01);
      if (slot_end && (st.tx_act || st.rx_act)) begin
        if (st.rx_act) begin
          n.rxbuf[st.idx] = st.rx_sh << (iasf_pkg::FULL_FIELD - ws_eff);
        end
        if (st.idx == buffer_length_field) begin
          ni = 2'h0;
          flag_set = 1'b1;
        end else begin
          ni = st.idx + 2'h1;
        end
      end
      n.idx = ni;
      if (st.link == iasf_pkg::LINK_RUN) begin
        if (st.bit_cnt >= frame_len - 10'h001) begin
          // Slave waits for a fresh sync after the full frame
          go = ~fs_dir;
          c = 10'h000;
        end else begin
          go = 1'b1;
          c = st.bit_cnt + 10'h001;
        end
      end else if (!fs_dir) begin
        go = 1'b1;
        c = 10'h000;
      end else begin
        // Sync changed one bit time ago
        go = i2s ? (fs_now != st.fs_prev) : (fs_now & ~st.fs_prev);
        c = 10'h001;
      end
      if (go) begin
        n.link = iasf_pkg::LINK_RUN;
        n.bit_cnt = c;
        if (ac) begin
          n.fs_out = ~fs_dir & (c < iasf_pkg::AC_FS_HIGH);
        end else if (i2s) begin
          n.fs_out = ~fs_dir & (c < half_len);
        end else begin
          n.fs_out = ~fs_dir & (c == 10'h000);
        end
        start = (c == delay) || (i2s && (c == half_len + delay));
        if (start) begin
          ndon = 1'b1;
          nslot = 4'h0;
          nsb = 5'h00;
        end else if (st.data_on && slot_end) begin
          ndon = (st.slot != last_slot);
          nslot = st.slot + 4'h1;
          nsb = 5'h00;
        end else if (st.data_on) begin
          ndon = 1'b1;
          nsb = st.sbit + 5'h01;
        end
      end else begin
        n.link = iasf_pkg::LINK_IDLE;
        n.fs_out = 1'b0;
      end
      n.data_on = ndon;
      n.slot = nslot;
      n.sbit = nsb;
      if (ndon && (nsb == 5'h00)) begin
        word = st.txbuf[ni];
        n.tx_act = tx_mask[nslot];
        n.rx_act = rx_mask[nslot];
        n.sdo = tx_mask[nslot] & word[15];
        n.tx_sh = {word[14:0], 1'b0};
        n.rx_sh = 16'h0000;
      end else if (ndon && st.tx_act) begin
        n.sdo = (nsb < iasf_pkg::WORD_BITS) & st.tx_sh[15];
        n.tx_sh = {st.tx_sh[14:0], 1'b0};
      end else if (!ndon) begin
        n.tx_act = 1'b0;
        n.rx_act = 1'b0;
        n.sdo = 1'b0;
      end
    end else if (sample_e && st.rx_act && st.data_on) begin
      // Bits past sixteen are dropped
      if (st.sbit < iasf_pkg::WORD_BITS) begin
        n.rx_sh = {st.rx_sh[14:0], st.sdi_sync[1]};
      end
    end
    // A new event beats a clear in the same cycle
    n.flag = (st.flag & ~flag_clr) | flag_set;
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      st <= '0;
    end else begin
      st <= n;
    end
  end

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = st.hrdata;
  assign serial_bit_clock_pin_out = st.sck_gen;
  assign serial_bit_clock_pin_oe_n = clk_dir;
  assign frame_sync_pin_out = st.fs_out;
  assign frame_sync_pin_oe_n = fs_dir;
  assign serial_data_out_pin_out = st.sdo;
  // Float unused slots so a second device can share the line
  assign serial_data_out_pin_oe_n = unused_mode & ~st.tx_act;
  assign interface_interrupt_flag = st.flag;

  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);

  property p_ac_fs;
    (st.link == iasf_pkg::LINK_RUN) && ac && !fs_dir && en
      |-> st.fs_out == (st.bit_cnt < iasf_pkg::AC_FS_HIGH);
  endproperty
  a_ac_fs: assert property (p_ac_fs) else $error("link sync width wrong");

  property p_i2s_fs;
    (st.link == iasf_pkg::LINK_RUN) && i2s && !fs_dir && en
      |-> st.fs_out == (st.bit_cnt < half_len);
  endproperty
  a_i2s_fs: assert property (p_i2s_fs) else $error("i2s sync duty wrong");

  property p_ac_len;
    (st.link == iasf_pkg::LINK_RUN) && ac && !fs_dir |-> st.bit_cnt < iasf_pkg::AC_FRAME;
  endproperty
  a_ac_len: assert property (p_ac_len) else $error("link frame too long");

  property p_pad;
    (mode == iasf_pkg::MODE_AC16) && st.data_on && (st.sbit >= iasf_pkg::WORD_BITS)
      |-> !st.sdo;
  endproperty
  a_pad: assert property (p_pad) else $error("pad bits not zero");

  property p_ac16_slots;
    (mode == iasf_pkg::MODE_AC16) && st.data_on |-> st.slot <= iasf_pkg::AC16_LAST;
  endproperty
  a_ac16_slots: assert property (p_ac16_slots) else $error("slot past twelve");

  property p_flag;
    $rose(st.flag) |-> ($past(st.idx) == $past(buffer_length_field)) && (st.idx == 2'h0);
  endproperty
  a_flag: assert property (p_flag) else $error("flag at wrong word count");

  property p_slave_quiet;
    fs_dir |=> !st.fs_out;
  endproperty
  a_slave_quiet: assert property (p_slave_quiet) else $error("slave drove sync");

  property p_ext_clk;
    clk_dir |=> !st.sck_gen && $stable(st.div_cnt);
  endproperty
  a_ext_clk: assert property (p_ext_clk) else $error("generator ran on ext clock");

  property p_unused;
    !st.tx_act |-> !st.sdo;
  endproperty
  a_unused: assert property (p_unused) else $error("data out in unused slot");

  property p_slave_hold;
    en && fs_dir && drive_e && (st.link == iasf_pkg::LINK_RUN)
      && (st.bit_cnt < frame_len - 10'h001)
      |=> st.link == iasf_pkg::LINK_RUN;
  endproperty
  a_slave_hold: assert property (p_slave_hold) else $error("slave frame cut short");

  property p_i2s_start;
    i2s && st.data_on && (st.slot == 4'h0) && (st.sbit == 5'h00) && !fs_dir
      |-> (st.bit_cnt == delay) || (st.bit_cnt == half_len + delay);
  endproperty
  a_i2s_start: assert property (p_i2s_start) else $error("i2s word misplaced");

  property p_ac_start;
    ac && st.data_on && (st.slot == 4'h0) && (st.sbit == 5'h00) |-> st.bit_cnt == 10'h001;
  endproperty
  a_ac_start: assert property (p_ac_start) else $error("link tag misplaced");

endmodule

// ==== tb/iasf_codec_model.sv ====
`timescale 1ns/1ps
module iasf_codec_model #(
  parameter logic [15:0] RX_WORD = 16'hA6D1
) (
  // Control from the bench
  input wire logic run,
  input wire logic sample_rise,
  // Link wires
  input wire logic bclk,
  input wire logic sync,
  input wire logic sdo,
  output logic bclk_gen,
  output logic sdi,
  // Observations
  output logic [9:0] last_hi,
  output logic [9:0] last_lo,
  output logic [35:0] word
);
  logic prev = 1'b0;
  logic [9:0] run_len = 10'h000;
  logic [9:0] pos = 10'h3FF;
  logic [9:0] cur;
  logic [35:0] shift = 36'h0;
  initial begin
    bclk_gen = 1'b0;
    sdi = 1'b0;
    last_hi = 10'h000;
    last_lo = 10'h000;
    word = 36'h0;
  end
  // Codec owns the link clock; it stands still outside runs
  always #32 if (run) bclk_gen = ~bclk_gen;
  always @(bclk) begin
    if (bclk === sample_rise) begin
      // Capture outlasts a short I2S frame, so restart only once it is done
      if (sync === 1'b1 && prev !== 1'b1 && pos >= 10'h024) begin
        cur = 10'h000;
      end else begin
        cur = pos + 10'h001;
      end
      if (sync !== prev) begin
        if (prev) last_hi = run_len;
        else last_lo = run_len;
        run_len = 10'h001;
      end else begin
        run_len = run_len + 10'h001;
      end
      // Latched copy, so a read mid-frame never sees a half shift
      if (cur != 10'h000 && cur <= 10'h024) shift = {shift[34:0], sdo};
      if (cur == 10'h024) word = shift;
      pos = cur;
      prev = sync;
    end else begin
      // Tag slot one bit after sync; otherwise a moving pattern
      sdi = (pos < 10'h010) ? RX_WORD[4'hF - pos[3:0]] : ~sdi;
    end
  end
endmodule

// ==== tb/tb_top.sv ====
`timescale 1ns/1ps
module tb_top;
  localparam logic [15:0] TX0 = 16'hC3A5;
  localparam logic [15:0] TX1 = 16'h5E17;
  localparam logic [15:0] TX2 = 16'h9B42;
  localparam logic [15:0] RX_WORD = 16'hA6D1;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic hreadyout, hresp, sck_out, sck_oe_n, fs_out, fs_oe_n, sdo, sdo_oe_n, flag;
  logic [31:0] hrdata;
  logic run = 1'b0;
  logic rise = 1'b0;
  logic sck_gen, sdi, bclk;
  logic [9:0] hi_len, lo_len;
  logic [35:0] word;
  logic [31:0] rd;
  int fails = 0;
  int tests_run = 0;
  int cyc = 0;
  always #4 clk = ~clk;
  always @(posedge clk) cyc <= cyc + 1;
  // Whoever enables the clock pin owns the wire
  assign bclk = sck_oe_n ? sck_gen : sck_out;
  iasf_serial_framing dut (
    .clk(clk), .rstn(rstn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(iasf_pkg::HSIZE_WORD), .hready(hreadyout),
    .hwdata(hwdata), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .serial_bit_clock_pin_in(bclk), .serial_bit_clock_pin_out(sck_out),
    .serial_bit_clock_pin_oe_n(sck_oe_n), .frame_sync_pin_in(fs_out),
    .frame_sync_pin_out(fs_out), .frame_sync_pin_oe_n(fs_oe_n),
    .serial_data_in_pin(sdi), .serial_data_out_pin_out(sdo),
    .serial_data_out_pin_oe_n(sdo_oe_n), .interface_interrupt_flag(flag)
  );
  iasf_codec_model #(.RX_WORD(RX_WORD)) codec (
    .run(run), .sample_rise(rise), .bclk(bclk), .sync(fs_out), .sdo(sdo),
    .bclk_gen(sck_gen), .sdi(sdi), .last_hi(hi_len), .last_lo(lo_len), .word(word)
  );
  task automatic check(input string name, input logic [35:0] seen, input logic [35:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic ahb(input logic wr_en, input logic [7:0] a, input logic [31:0] wd);
    @(posedge clk);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= wr_en;
    @(posedge clk);
    while (hreadyout !== 1'b1) @(posedge clk);
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge clk);
    while (hreadyout !== 1'b1) @(posedge clk);
    rd = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    ahb(1'b1, a, d);
  endtask
  task automatic rdchk(input string name, input logic [7:0] a, input logic [31:0] exp);
    ahb(1'b0, a, 32'h0);
    check(name, 36'(rd), 36'(exp));
  endtask
  task automatic wait_flag;
    // Step past the edge so the flag is read once it has settled
    #1;
    for (int i = 0; i < 600 && flag !== 1'b1; i++) begin
      @(posedge clk);
      #1;
    end
  endtask
  task automatic reg_test;
    rdchk("ctrl1 reset", iasf_pkg::OFF_CTRL1, 32'h0);
    rdchk("status reset", iasf_pkg::OFF_STATUS, 32'h0);
    check("hresp", 36'(hresp), 36'h0);
    wr(iasf_pkg::OFF_CTRL1, 32'h7FFF);
    rdchk("ctrl1 rw", iasf_pkg::OFF_CTRL1, {16'h0, iasf_pkg::CTRL1_WMASK & 16'h7FFF});
    wr(iasf_pkg::OFF_CTRL1, 32'h0);
    wr(8'h40, 32'hFFFF);
    rdchk("unmapped", 8'h40, 32'h0);
  endtask
  task automatic i2s(input logic just);
    int t0;
    wr(iasf_pkg::OFF_CTRL1, 32'h0);
    rise <= 1'b1;
    wr(iasf_pkg::OFF_CLKGEN, 32'h1);
    wr(iasf_pkg::OFF_CTRL2, 32'h040F);
    wr(iasf_pkg::OFF_TXEN, 32'h1);
    wr(8'h20, {16'h0, TX0});
    wr(8'h24, {16'h0, TX1});
    wr(iasf_pkg::OFF_CTRL1, 32'h8201 | (32'(just) << 5));
    repeat (600) @(posedge clk);
    check("i2s clk oe_n", 36'(sck_oe_n), 36'h0);
    check("i2s fs oe_n", 36'(fs_oe_n), 36'h0);
    check("i2s high", 36'(hi_len), 36'h10);
    check("i2s low", 36'(lo_len), 36'h10);
    if (just) check("just word", 36'(word[35:20]), 36'({TX0[14:0], TX1[15]}));
    else check("i2s word", 36'(word[35:4]), 36'({TX0, TX1}));
    wr(iasf_pkg::OFF_STATUS, 32'h1);
    wait_flag;
    t0 = cyc;
    wr(iasf_pkg::OFF_STATUS, 32'h1);
    wait_flag;
    check("flag set", 36'(flag), 36'h1);
    // Gap between two sets does not depend on pipeline lag
    check("flag gap", 36'(cyc - t0), 36'h80);
  endtask
  task automatic link(input logic [1:0] mode, input logic [35:0] exp);
    wr(iasf_pkg::OFF_CTRL1, 32'h0);
    rise <= 1'b0;
    run <= 1'b1;
    wr(iasf_pkg::OFF_CTRL2, 32'h0823);
    wr(iasf_pkg::OFF_TXEN, 32'h7);
    wr(iasf_pkg::OFF_RXEN, 32'h1);
    wr(8'h20, {16'h0, TX0});
    wr(8'h24, {16'h0, TX1});
    wr(8'h28, {16'h0, TX2});
    wr(iasf_pkg::OFF_CTRL1, 32'h8440 | 32'(mode));
    repeat (6400) @(posedge clk);
    check("link high", 36'(hi_len), 36'h10);
    check("link low", 36'(lo_len), 36'hF0);
    check("link bits", word, exp);
    rdchk("link rx", 8'h30, {16'h0, RX_WORD});
    check("link clk oe_n", 36'(sck_oe_n), 36'h1);
    check("link fs oe_n", 36'(fs_oe_n), 36'h0);
    // Sync falls at bit 16; bit 46 lies in slot 2, bit 86 in slot 4 or 5
    @(negedge fs_out);
    repeat (240) @(posedge clk);
    #1;
    check("sdo oe_n used slot", 36'(sdo_oe_n), 36'h0);
    repeat (320) @(posedge clk);
    #1;
    check("sdo oe_n unused slot", 36'(sdo_oe_n), 36'h1);
    wr(iasf_pkg::OFF_CTRL1, 32'h0);
    run <= 1'b0;
  endtask
  task automatic complete_run;
    $display("Comparisons %0d, mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  initial begin
    repeat (4) @(posedge clk);
    rstn <= 1'b1;
    reg_test;
    i2s(1'b0);
    i2s(1'b1);
    link(2'h2, {TX0, TX1, 4'h0});
    link(2'h3, {TX0, TX1, TX2[15:12]});
    complete_run;
  end
  initial begin
    repeat (40000) @(posedge clk);
    fails++;
    complete_run;
  end
endmodule
